// ==== pkg/cal_sec_pkg.sv ====
// Package: register map, field layouts and constants of the calibration security block
package cal_sec_pkg;

    localparam int CODE_LEN = 12;
    localparam logic [7:0] REG_CTRL_OFS = 8'h00;
    localparam logic [7:0] REG_STATUS_OFS = 8'h04;
    localparam logic [7:0] REG_COUNT_OFS = 8'h08;
    localparam logic [7:0] REG_IRQ_STAT_OFS = 8'h0c;
    localparam logic [7:0] REG_IRQ_MASK_OFS = 8'h10;
    localparam logic [7:0] REG_CHAR_OFS = 8'h14;
    localparam logic [7:0] REG_CMD_OFS = 8'h18;
    localparam logic [7:0] REG_REF_OFS = 8'h1c;
    localparam logic [7:0] REG_ERR_OFS = 8'h20;

    localparam int CMD_UNLOCK = 0;
    localparam int CMD_LOCK = 1;
    localparam int CMD_SETCODE = 2;
    localparam int CMD_CAL = 3;
    localparam int CMD_CLRBUF = 4;
    localparam int CMD_COMMIT = 5;
    localparam int CMD_LOCK_NOCODE = 6;

    localparam int ST_LOCKED_BIT = 0;
    localparam int ST_RESULT_BIT = 1;
    localparam int ST_BUSY_BIT = 2;

    localparam int EV_DONE_BIT = 0;
    localparam int EV_ERR_BIT = 1;

    localparam logic [14:0] COUNT_MAX = 15'h7fff;
    localparam logic LOCKED_RESET = 1'b1;
    localparam logic [31:0] CAL_TOL_RESET = 32'h0000_0100;

    localparam logic [7:0] ERR_NONE = 8'h00;
    localparam logic [7:0] ERR_CAL_FAIL = 8'h01;
    localparam logic [7:0] ERR_CODE_BAD = 8'h02;
    localparam logic [7:0] ERR_SECURED = 8'h03;
    localparam logic [7:0] ERR_FORMAT = 8'h04;

    typedef struct packed {
        logic [7:0] addr;
        logic write;
        logic [31:0] wdata;
    } apb_req_t;

    typedef struct packed {
        logic passed;
        logic [7:0] err;
    } result_t;

endpackage : cal_sec_pkg

// ==== rtl/cal_sec.sv ====
// Calibration security, calibration counter and command interpreter
//
// What this block does
// - Calibrate query answers 0 pass, 1 fail
// - Calibration runs only when unsecured
// - Failed calibration also logs an error
// - Every calibrate query bumps the counter
// - Counter tops at 32767 then wraps zero
// - Counter rises one per calibrate query, pass or fail
// - Counter readable whether secured or not
// - Counter kept nonvolatile, reset never clears
// - New code accepted only when unsecured
// - New code: letter then letters/digits, max 12
// - Lock code: letter then alnum/underscore, max 12
// - Unlock needs code; lock code optional, checked
// - Lock state set 0/1, queried as 0/1
// - Factory state secured with default code
// - One stored code for panel and remote
// - Code kept nonvolatile across reset
// - Lock state kept nonvolatile across reset
// - Commit adjustments only after all points done
`timescale 1ns/1ps
`default_nettype none

module cal_sec #(
    parameter int POINTS = 7,
    // Arbitrary value
    parameter logic [8*cal_sec_pkg::CODE_LEN-1:0] DEFAULT_CODE = 96'h5a5a_5157_3130_3030_0000_0000
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Factory restore of the nonvolatile code and lock state, one-cycle pulse
    input wire logic factory_init_i,
    // Front panel path, same code store
    input wire logic panel_unlock_i,
    input wire logic panel_lock_i,
    // Measured reading for the calibration step
    input wire logic [31:0] meas_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Status outputs
    output logic locked_o,
    output logic commit_o,
    output logic irq_o
);
    import cal_sec_pkg::*;

    localparam int LW = $clog2(CODE_LEN + 1);
    localparam int PW = $clog2(POINTS + 1);

    typedef logic [8*CODE_LEN-1:0] code_t;

    function automatic logic is_letter(input logic [7:0] c);
        return c >= 8'h41 && c <= 8'h5a;
    endfunction : is_letter

    function automatic logic is_digit(input logic [7:0] c);
        return c >= 8'h30 && c <= 8'h39;
    endfunction : is_digit

    // Checks a buffered code; allow_us selects the lock-command alphabet
    function automatic logic code_ok(input code_t b, input logic [LW-1:0] n,
                                     input logic allow_us);
        logic ok;
        ok = (n != '0) && is_letter(b[8*CODE_LEN-1 -: 8]);
        for (int i = 1; i < CODE_LEN; i++) begin
            if (i < int'(n)) begin
                if (!(is_letter(b[8*(CODE_LEN-1-i) +: 8]) || is_digit(b[8*(CODE_LEN-1-i) +: 8])
                      || (allow_us && b[8*(CODE_LEN-1-i) +: 8] == 8'h5f))) begin
                    ok = 1'b0;
                end
            end
        end
        return ok;
    endfunction : code_ok

    // Nonvolatile-style state: factory_init_i restores code and lock, never rst_i
    code_t code_reg, code_next;
    logic locked_reg, locked_next;
    logic [14:0] count_reg, count_next;
    // Blank store at power-up; triggers the one-time factory fill
    logic nv_valid_reg = 1'b0;
    logic nv_valid_next;

    // Volatile state
    code_t buf_reg, buf_next;
    logic [LW-1:0] len_reg, len_next;
    logic [31:0] ref_reg, ref_next;
    logic [31:0] tol_reg, tol_next;
    logic [PW-1:0] points_reg, points_next;
    logic result_reg, result_next;
    logic [7:0] err_reg, err_next;
    logic [1:0] ev_reg, ev_next;
    logic [1:0] mask_reg, mask_next;
    logic commit_reg, commit_next;
    logic irq_reg, irq_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;

    apb_req_t req;
    logic wr_en;
    logic rd_en;
    logic [31:0] diff;
    result_t cal_res;

    always_comb begin
        req.addr = paddr_i;
        req.write = pwrite_i;
        req.wdata = pwdata_i;
        // Answer one cycle after the access phase starts
        wr_en = psel_i && penable_i && !pready_reg && req.write;
        rd_en = psel_i && penable_i && !pready_reg && !req.write;
        diff = (meas_i >= ref_reg) ? meas_i - ref_reg : ref_reg - meas_i;
        cal_res.passed = diff <= tol_reg;
        cal_res.err = cal_res.passed ? ERR_NONE : ERR_CAL_FAIL;
    end

    always_comb begin
        logic [1:0] ev_set;
        logic [7:0] new_err;
        logic [3:0] cmd;
        ev_set = 2'b00;
        new_err = ERR_NONE;
        cmd = req.wdata[3:0];
        code_next = code_reg;
        locked_next = locked_reg;
        count_next = count_reg;
        nv_valid_next = nv_valid_reg;
        buf_next = buf_reg;
        len_next = len_reg;
        ref_next = ref_reg;
        tol_next = tol_reg;
        points_next = points_reg;
        result_next = result_reg;
        err_next = err_reg;
        mask_next = mask_reg;
        commit_next = 1'b0;
        prdata_next = prdata_reg;
        pready_next = psel_i && penable_i && !pready_reg;
        pslverr_next = 1'b0;

        // Factory restore of secured state and default code
        if (factory_init_i || !nv_valid_reg) begin
            code_next = DEFAULT_CODE;
            locked_next = 1'b1;
            nv_valid_next = 1'b1;
        end
        // Counter starts from zero only on a blank store, never on restore
        if (!nv_valid_reg) begin
            count_next = '0;
        end
        if (panel_lock_i) begin
            locked_next = 1'b1;
        end else if (panel_unlock_i && buf_reg == code_reg && len_reg != '0) begin
            locked_next = 1'b0;
        end

        if (wr_en) begin
            unique case (req.addr)
                REG_CTRL_OFS: tol_next = req.wdata;
                REG_IRQ_MASK_OFS: mask_next = req.wdata[1:0];
                REG_REF_OFS: ref_next = req.wdata;
                REG_IRQ_STAT_OFS: ;
                REG_CHAR_OFS: begin
                    if (len_reg < LW'(CODE_LEN)) begin
                        buf_next[8*(CODE_LEN-1-int'(len_reg)) +: 8] = req.wdata[7:0];
                        len_next = len_reg + 1'b1;
                    end else begin
                        new_err = ERR_FORMAT;
                    end
                end
                REG_CMD_OFS: begin
                    if (cmd == 4'(CMD_UNLOCK)) begin
                        if (code_ok(buf_reg, len_reg, 1'b1) && buf_reg == code_reg) begin
                            locked_next = 1'b0;
                        end else begin
                            new_err = ERR_CODE_BAD;
                        end
                    end else if (cmd == 4'(CMD_LOCK)) begin
                        if (code_ok(buf_reg, len_reg, 1'b1) && buf_reg == code_reg) begin
                            locked_next = 1'b1;
                        end else begin
                            new_err = ERR_CODE_BAD;
                        end
                    end else if (cmd == 4'(CMD_LOCK_NOCODE)) begin
                        locked_next = 1'b1;
                    end else if (cmd == 4'(CMD_SETCODE)) begin
                        if (locked_reg) begin
                            new_err = ERR_SECURED;
                        end else if (!code_ok(buf_reg, len_reg, 1'b0)) begin
                            new_err = ERR_FORMAT;
                        end else begin
                            code_next = buf_reg;
                        end
                    end else if (cmd == 4'(CMD_CAL)) begin
                        // Counter also bumps on a refused attempt: each query counts
                        count_next = (count_reg == COUNT_MAX) ? '0 : count_reg + 1'b1;
                        if (locked_reg) begin
                            result_next = 1'b1;
                            new_err = ERR_SECURED;
                        end else begin
                            result_next = !cal_res.passed;
                            new_err = cal_res.err;
                            if (cal_res.passed && points_reg < PW'(POINTS)) begin
                                points_next = points_reg + 1'b1;
                            end
                        end
                        ev_set[EV_DONE_BIT] = 1'b1;
                    end else if (cmd == 4'(CMD_COMMIT)) begin
                        if (points_reg == PW'(POINTS)) begin
                            commit_next = 1'b1;
                            points_next = '0;
                        end else begin
                            new_err = ERR_FORMAT;
                        end
                    end else if (cmd == 4'(CMD_CLRBUF)) begin
                        buf_next = '0;
                        len_next = '0;
                    end else begin
                        new_err = ERR_FORMAT;
                    end
                    if (cmd != 4'(CMD_CLRBUF) && cmd != 4'(CMD_CAL) && cmd != 4'(CMD_COMMIT)) begin
                        buf_next = '0;
                        len_next = '0;
                    end
                end
                default: pslverr_next = 1'b1;
            endcase
        end

        if (rd_en) begin
            unique case (req.addr)
                REG_CTRL_OFS: prdata_next = tol_reg;
                REG_STATUS_OFS: prdata_next = {29'h0, 1'b0, result_reg, locked_reg};
                REG_COUNT_OFS: prdata_next = {17'h0, count_reg};
                REG_IRQ_STAT_OFS: prdata_next = {30'h0, ev_reg};
                REG_IRQ_MASK_OFS: prdata_next = {30'h0, mask_reg};
                REG_REF_OFS: prdata_next = ref_reg;
                REG_ERR_OFS: prdata_next = {24'h0, err_reg};
                REG_CHAR_OFS, REG_CMD_OFS: prdata_next = 32'h0;
                default: begin
                    prdata_next = 32'h0;
                    pslverr_next = 1'b1;
                end
            endcase
            // Reading the error word pops it, a later error overrides
            if (req.addr == REG_ERR_OFS) begin
                err_next = ERR_NONE;
            end
        end

        if (new_err != ERR_NONE) begin
            err_next = new_err;
            ev_set[EV_ERR_BIT] = 1'b1;
        end
        // Set wins over write-one-to-clear
        ev_next = ev_reg;
        if (wr_en && req.addr == REG_IRQ_STAT_OFS) begin
            ev_next = ev_reg & ~req.wdata[1:0];
        end
        ev_next = ev_next | ev_set;
        irq_next = |(ev_next & mask_reg);
    end

    // Nonvolatile copies ignore rst_i so they survive resets
    always_ff @(posedge clk_i) begin
        code_reg <= code_next;
        locked_reg <= locked_next;
        count_reg <= count_next;
        nv_valid_reg <= nv_valid_next;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            buf_reg <= '0;
            len_reg <= '0;
            ref_reg <= 32'h0;
            tol_reg <= CAL_TOL_RESET;
            points_reg <= '0;
            result_reg <= 1'b0;
            err_reg <= ERR_NONE;
            ev_reg <= 2'b00;
            mask_reg <= 2'b00;
            commit_reg <= 1'b0;
            irq_reg <= 1'b0;
            prdata_reg <= 32'h0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            buf_reg <= buf_next;
            len_reg <= len_next;
            ref_reg <= ref_next;
            tol_reg <= tol_next;
            points_reg <= points_next;
            result_reg <= result_next;
            err_reg <= err_next;
            ev_reg <= ev_next;
            mask_reg <= mask_next;
            commit_reg <= commit_next;
            irq_reg <= irq_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    always_comb begin
        prdata_o = prdata_reg;
        pready_o = pready_reg;
        pslverr_o = pslverr_reg;
        locked_o = locked_reg;
        commit_o = commit_reg;
        irq_o = irq_reg;
    end

endmodule : cal_sec
`default_nettype wire

// ==== tb/cal_sec_assertions.sv ====
// Bus timing and lock state checks for the calibration security block
`timescale 1ns/1ps
`default_nettype none
module cal_sec_checker (
    // Watched ports
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic factory_init_i,
    input wire logic panel_unlock_i,
    input wire logic panel_lock_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic locked_o,
    input wire logic commit_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_ready_one_cycle: assert property (pready_o |=> !pready_o)
        else $error("ready held longer than one cycle");
    chk_single_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o)
        else $error("ready not one cycle after access");
    chk_error_on_ready: assert property (pslverr_o |-> pready_o && $past(psel_i && penable_i))
        else $error("slave error outside an answer");
    chk_panel_secures: assert property (panel_lock_i |-> ##[1:3] locked_o)
        else $error("panel lock did not secure");
    chk_factory_secures: assert property (factory_init_i |-> ##[1:3] locked_o)
        else $error("factory restore left block unsecured");
    chk_unlock_cause: assert property ($fell(locked_o) |-> $past(psel_i && pwrite_i)
        || $past(panel_unlock_i) || $past(panel_unlock_i, 2))
        else $error("unlocked with no request");
    chk_commit_pulse: assert property (commit_o |=> !commit_o)
        else $error("commit longer than one cycle");
    chk_commit_cause: assert property (commit_o |-> $past(psel_i && pwrite_i))
        else $error("commit without a command write");
    cov_commit: cover property (commit_o);
    cov_refused: cover property (pslverr_o);
    cov_unlock: cover property ($fell(locked_o));
endmodule : cal_sec_checker
bind cal_sec cal_sec_checker cal_sec_checker_i (.clk_i, .rst_i, .factory_init_i,
    .panel_unlock_i, .panel_lock_i, .psel_i, .penable_i, .pwrite_i, .pready_o,
    .pslverr_o, .locked_o, .commit_o);
`default_nettype wire

// ==== tb/apb_host.sv ====
// Remote host stand-in: APB master carrying command and register traffic
`timescale 1ns/1ps
`default_nettype none
module apb_host (
    // Clock
    input wire logic clk_i,
    // APB master side
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [7:0] paddr_o,
    output logic [31:0] pwdata_o,
    input wire logic [31:0] prdata_i,
    input wire logic pready_i,
    input wire logic pslverr_i
);
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 8'h00;
        pwdata_o = 32'h0;
    end
    // Idle edge first, so a release never meets the next setup in one step
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge clk_i);
        psel_o <= 1'b1;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge clk_i);
        penable_o <= 1'b1;
        // Sample the answer at the rising edge that sees ready high
        do @(posedge clk_i); while (pready_i !== 1'b1);
        q = prdata_i;
        e = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
    endtask : xfer
endmodule : apb_host
`default_nettype wire

// ==== tb/test_cal_sec.sv ====
// Self-checking bench for the calibration security block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fail_count++; \
    $display("mismatch t=%0t got %h exp %h", $time, (a), (e)); end end
module test_cal_sec;
    import cal_sec_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic factory_init_i = 1'b0;
    logic panel_unlock_i = 1'b0;
    logic panel_lock_i = 1'b0;
    logic [31:0] meas_i = 32'h0;
    logic psel, penable, pwrite, pready, pslverr, locked_o, commit_o, irq_o, last_err;
    logic seen = 1'b0;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [14:0] cnt;
    int fail_count = 0;
    int n_compared = 0;
    int cyc = 0;
    always #2 clk_i = ~clk_i;
    cal_sec #(.POINTS(7), .DEFAULT_CODE({"KV9T", 64'h0})) cal_sec_i (.clk_i, .rst_i,
        .factory_init_i, .panel_unlock_i, .panel_lock_i, .meas_i, .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .locked_o,
        .commit_o, .irq_o);
    apb_host apb_host_i (.clk_i, .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
        .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready),
        .pslverr_i(pslverr));
    always @(posedge clk_i) begin
        if (commit_o === 1'b1) seen <= 1'b1;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            stop_test();
        end
    end
    task automatic stop_test;
        $display("fail_count=%0d n_compared=%0d", fail_count, n_compared);
        if (fail_count == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : stop_test
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb_host_i.xfer(1'b1, a, d, r, last_err);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        apb_host_i.xfer(1'b0, a, 32'h0, r, last_err);
    endtask : rd
    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        rd(a, q);
        `CHK(q & m, x)
    endtask : rchk
    // Waits out busy so later reads see the finished command
    task automatic cmd(input int c);
        wr(REG_CMD_OFS, 32'(c));
        if (c == CMD_CAL) cnt = cnt + 15'h1;
        do rd(REG_STATUS_OFS, q); while (q[ST_BUSY_BIT] !== 1'b0);
    endtask : cmd
    task automatic code(input string s);
        cmd(CMD_CLRBUF);
        foreach (s[i]) wr(REG_CHAR_OFS, {24'h0, s[i]});
    endtask : code
    task automatic t_secured;
        rchk(REG_STATUS_OFS, 32'h1, 32'h1);
        rd(REG_COUNT_OFS, q);
        cnt = q[14:0];
        cmd(CMD_CAL);
        rchk(REG_ERR_OFS, 32'hff, {24'h0, ERR_SECURED});
        rchk(REG_COUNT_OFS, 32'h7fff, {17'h0, cnt});
        rchk(8'h40, 32'hffffffff, 32'h0);
        `CHK(last_err, 1'b1)
    endtask : t_secured
    task automatic t_irq;
        wr(REG_IRQ_MASK_OFS, 32'h0);
        code("KV9Q");
        cmd(CMD_UNLOCK);
        `CHK(locked_o, 1'b1)
        rchk(REG_ERR_OFS, 32'hff, {24'h0, ERR_CODE_BAD});
        `CHK(irq_o, 1'b0)
        wr(REG_IRQ_MASK_OFS, 32'h2);
        repeat (2) @(posedge clk_i);
        `CHK(irq_o, 1'b1)
        wr(REG_IRQ_STAT_OFS, 32'h3);
        repeat (2) @(posedge clk_i);
        `CHK(irq_o, 1'b0)
    endtask : t_irq
    task automatic t_cal;
        rchk(REG_CTRL_OFS, 32'hffffffff, CAL_TOL_RESET);
        code("KV9T");
        cmd(CMD_UNLOCK);
        `CHK(locked_o, 1'b0)
        wr(REG_REF_OFS, 32'd1000);
        meas_i <= 32'd1000 + CAL_TOL_RESET;
        cmd(CMD_CAL);
        rchk(REG_STATUS_OFS, 32'h3, 32'h0);
        meas_i <= 32'd1001 + CAL_TOL_RESET;
        cmd(CMD_CAL);
        rchk(REG_STATUS_OFS, 32'h3, 32'h2);
        rchk(REG_ERR_OFS, 32'hff, {24'h0, ERR_CAL_FAIL});
        rchk(REG_COUNT_OFS, 32'h7fff, {17'h0, cnt});
    endtask : t_cal
    task automatic t_commit;
        seen = 1'b0;
        cmd(CMD_COMMIT);
        `CHK(seen, 1'b0)
        meas_i <= 32'd1000;
        repeat (7) cmd(CMD_CAL);
        cmd(CMD_COMMIT);
        `CHK(seen, 1'b1)
    endtask : t_commit
    task automatic t_code;
        code("ABCDEFGHIJKLM");
        rchk(REG_ERR_OFS, 32'hff, {24'h0, ERR_FORMAT});
        code("7A");
        cmd(CMD_SETCODE);
        rchk(REG_ERR_OFS, 32'hff, {24'h0, ERR_FORMAT});
        code("B7");
        cmd(CMD_SETCODE);
        cmd(CMD_LOCK_NOCODE);
        `CHK(locked_o, 1'b1)
        code("C1");
        cmd(CMD_SETCODE);
        rchk(REG_ERR_OFS, 32'hff, {24'h0, ERR_SECURED});
        code("KV9T");
        cmd(CMD_UNLOCK);
        `CHK(locked_o, 1'b1)
        code("B7");
        @(posedge clk_i) panel_unlock_i <= 1'b1;
        @(posedge clk_i) panel_unlock_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        `CHK(locked_o, 1'b0)
        code("B7");
        cmd(CMD_LOCK);
        `CHK(locked_o, 1'b1)
    endtask : t_code
    task automatic t_nv;
        code("B7");
        cmd(CMD_UNLOCK);
        @(posedge clk_i) rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        `CHK(locked_o, 1'b0)
        rchk(REG_COUNT_OFS, 32'h7fff, {17'h0, cnt});
        @(posedge clk_i) panel_lock_i <= 1'b1;
        @(posedge clk_i) panel_lock_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        `CHK(locked_o, 1'b1)
        code("B7");
        cmd(CMD_UNLOCK);
        `CHK(locked_o, 1'b0)
        @(posedge clk_i) factory_init_i <= 1'b1;
        @(posedge clk_i) factory_init_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        `CHK(locked_o, 1'b1)
        rchk(REG_COUNT_OFS, 32'h7fff, {17'h0, cnt});
        code("KV9T");
        cmd(CMD_UNLOCK);
        `CHK(locked_o, 1'b0)
    endtask : t_nv
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        t_secured();
        t_irq();
        t_cal();
        t_commit();
        t_code();
        t_nv();
        stop_test();
    end
endmodule : test_cal_sec
`default_nettype wire
